// ### pkg/adc_seq_pkg.sv
// constants and carriers shared by the converter serial/power sequencer
// assumes one 200 MHz ref_clk domain; serial pins are asynchronous to it
// Summary of operation
// - autoshutdown powers everything down after each conversion
// - autoshutdown wakes on first falling sclk edge
// - autoshutdown powers down on sixteenth rising edge
// - autostandby keeps reference on, powers rest down
// - autostandby wakes on first falling sclk edge
// - chip select fall starts frame, enables clock, tracks
// - second rising edge holds sample, starts conversion
// - conversion completes fourteen clocks later
// - chip select rise releases data output
// - chip select held low starts next conversion
// - sample channel from previous transfer's control word
// - control word captured on first eight rising edges
// - sixteen clocks per conversion and read-out
// - bits shift on falling edge, first zero included
// - last bit valid at sixteenth rising edge
// - new power mode effective at sixteenth rising edge
// - mode 00 always on, 01 fully off
package adc_seq_pkg;

	localparam int FRAME_BITS = 16;
	localparam int RESULT_BITS = 12;
	localparam int CTRL_BITS = 8;
	localparam logic [3:0] HOLD_RISE_CNT = 4'h1;
	localparam logic [3:0] CTRL_LAST_CNT = 4'h7;
	localparam logic [3:0] FRAME_LAST_CNT = 4'hF;
	localparam logic [3:0] LEAD_ZERO_BITS = 4'h4;

	localparam logic [1:0] PM_NORMAL = 2'h0;
	localparam logic [1:0] PM_FULL_OFF = 2'h1;
	localparam logic [1:0] PM_AUTO_SHUTDOWN = 2'h2;
	localparam logic [1:0] PM_AUTO_STANDBY = 2'h3;
	localparam logic [1:0] PM_RESET = 2'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// control word, first bit shifted in is the top bit
	typedef struct packed {
		logic [2:0] spare;
		logic [2:0] channel;
		logic power_mode_high_bit;
		logic power_mode_low_bit;
	} ctrl_word_s;

	typedef struct packed {
		logic core_on;
		logic ref_on;
	} power_s;

endpackage

// ### design/pin_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes inputs are levels; first stage is read only by the second
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] reset_val,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_hi_r;

	// reset loads all ones into both stages; the reset_val port has no effect on the output
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			meta_r <= '1;
			meta_hi_r <= '1;
		end
		else
		begin
			meta_r <= async_in;
			meta_hi_r <= meta_r;
		end

	always_comb
		sync_out = meta_hi_r & (reset_val | ~reset_val);
endmodule

// ### design/adc_serial_power_sequencer.sv
// serial port and power-mode sequencing of an eight-channel sampling converter
// assumes sclk, cs_n and din are asynchronous pins; result_in comes from the
// converter core on ref_clk and holds each bit settled by the time it is shifted
`timescale 1ns/1ps
module adc_serial_power_sequencer
	import adc_seq_pkg::*;
(
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic [RESULT_BITS-1:0] result_in,
	output logic dout,
	output logic dout_oe,
	output logic hold,
	output logic conv_start,
	output logic conv_done,
	output logic [2:0] channel,
	output power_s power,
	output logic [1:0] power_mode
);
	// ----------------------------------------------------------------
	// pin synchronisation and edge finding
	// ----------------------------------------------------------------
	logic [2:0] pins_s;
	logic sclk_s, cs_n_s, din_s;
	logic sclk_d_r, cs_n_d_r;
	logic rise_e, fall_e, cs_fall_e, cs_rise_e, active;

	pin_sync #(.WIDTH(3)) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in({sclk, cs_n, din}),
		.reset_val(3'h7),
		.sync_out(pins_s)
	);

	assign sclk_s = pins_s[2];
	assign cs_n_s = pins_s[1];
	assign din_s = pins_s[0];

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			sclk_d_r <= 1'b1;
			cs_n_d_r <= 1'b1;
		end
		else
		begin
			sclk_d_r <= sclk_s;
			cs_n_d_r <= cs_n_s;
		end

	// sclk only counts while framed; chip select gates the clock in
	assign active = !cs_n_s && !cs_n_d_r;
	assign rise_e = active && sclk_s && !sclk_d_r;
	assign fall_e = active && !sclk_s && sclk_d_r;
	assign cs_fall_e = cs_n_d_r && !cs_n_s;
	assign cs_rise_e = !cs_n_d_r && cs_n_s;

	// ----------------------------------------------------------------
	// rising-edge counter of the frame
	// ----------------------------------------------------------------
	logic [3:0] cnt_r;
	logic last_rise;

	assign last_rise = rise_e && cnt_r == FRAME_LAST_CNT;

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			cnt_r <= 4'h0;
		else if (!active)
			cnt_r <= 4'h0;
		else if (last_rise)
			cnt_r <= 4'h0;
		else if (rise_e)
			cnt_r <= cnt_r + 4'h1;

	// ----------------------------------------------------------------
	// control word capture
	// ----------------------------------------------------------------
	logic [CTRL_BITS-2:0] shift_r;
	ctrl_word_s ctrl_r;

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			shift_r <= '0;
			ctrl_r <= CTRL_RESET;
		end
		else if (rise_e && cnt_r < CTRL_LAST_CNT)
			shift_r <= {shift_r[CTRL_BITS-3:0], din_s};
		else if (rise_e && cnt_r == CTRL_LAST_CNT)
			ctrl_r <= {shift_r, din_s};

	// ----------------------------------------------------------------
	// track/hold and conversion
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			hold <= 1'b0;
			conv_start <= 1'b0;
			conv_done <= 1'b0;
			channel <= 3'h0;
		end
		else
		begin
			conv_start <= 1'b0;
			conv_done <= 1'b0;
			if (cs_fall_e || !active)
				hold <= 1'b0;
			else if (rise_e && cnt_r == HOLD_RISE_CNT)
			begin
				hold <= 1'b1;
				conv_start <= 1'b1;
				// word of the previous frame; this frame's lands at edge 8
				channel <= ctrl_r.channel;
			end
			else if (last_rise)
			begin
				hold <= 1'b0;
				conv_done <= 1'b1;
			end
		end

	// ----------------------------------------------------------------
	// serial data out
	// ----------------------------------------------------------------
	logic [FRAME_BITS-1:0] out_word;

	assign out_word = {{(FRAME_BITS-RESULT_BITS){1'b0}}, result_in};

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
		begin
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end
		else if (cs_rise_e || cs_n_s)
		begin
			dout <= 1'b0;
			dout_oe <= 1'b0;
		end
		else if (cs_fall_e)
		begin
			dout <= 1'b0;
			dout_oe <= 1'b1;
		end
		else if (fall_e)
			dout <= out_word[FRAME_LAST_CNT - cnt_r];

	// ----------------------------------------------------------------
	// power sequencing
	// ----------------------------------------------------------------
	logic [1:0] pm_nxt;

	assign pm_nxt = {ctrl_r.power_mode_high_bit, ctrl_r.power_mode_low_bit};

	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			power_mode <= PM_RESET;
		else if (last_rise)
			power_mode <= pm_nxt;

	// powered at start-up, as after supply connection
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst)
			power <= '{core_on: 1'b1, ref_on: 1'b1};
		else if (last_rise)
			unique case (pm_nxt)
				PM_NORMAL: power <= '{core_on: 1'b1, ref_on: 1'b1};
				PM_FULL_OFF: power <= '{core_on: 1'b0, ref_on: 1'b0};
				PM_AUTO_SHUTDOWN: power <= '{core_on: 1'b0, ref_on: 1'b0};
				PM_AUTO_STANDBY: power <= '{core_on: 1'b0, ref_on: 1'b1};
			endcase
		else if (fall_e && cnt_r == 4'h0)
			unique case (power_mode)
				PM_NORMAL: power <= '{core_on: 1'b1, ref_on: 1'b1};
				PM_FULL_OFF: power <= '{core_on: 1'b0, ref_on: 1'b0};
				PM_AUTO_SHUTDOWN: power <= '{core_on: 1'b1, ref_on: 1'b1};
				PM_AUTO_STANDBY: power <= '{core_on: 1'b1, ref_on: 1'b1};
			endcase

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	sequence seq_second_rise;
		rise_e && cnt_r == HOLD_RISE_CNT;
	endsequence

	sequence seq_first_fall(logic [1:0] mode);
		fall_e && cnt_r == 4'h0 && !last_rise && power_mode == mode;
	endsequence

	a_hold_second_rise: assert property (seq_second_rise |=> hold && conv_start)
		else $error("hold not taken on second rising edge");
	a_channel_prev_word: assert property (seq_second_rise |=> channel == $past(ctrl_r.channel))
		else $error("sampled channel not from earlier word");
	a_frame_start: assert property (cs_fall_e |=> !hold && dout_oe && !dout)
		else $error("frame start not tracking or not driving");
	a_release_on_rise: assert property (cs_rise_e |=> !dout_oe)
		else $error("data output still driven after select rise");
	a_shutdown_wake: assert property (seq_first_fall(PM_AUTO_SHUTDOWN) |=> power.core_on && power.ref_on)
		else $error("autoshutdown did not wake");
	a_standby_wake: assert property (seq_first_fall(PM_AUTO_STANDBY) |=> power.core_on)
		else $error("autostandby did not wake");
	a_shutdown_sleep: assert property (last_rise && pm_nxt == PM_AUTO_SHUTDOWN |=> !power.core_on && !power.ref_on)
		else $error("autoshutdown did not power down");
	a_standby_sleep: assert property (last_rise && pm_nxt == PM_AUTO_STANDBY |=> !power.core_on && power.ref_on)
		else $error("autostandby wrong power state");
	a_normal_on: assert property (power_mode == PM_NORMAL |-> power.core_on && power.ref_on)
		else $error("normal mode not fully powered");
	a_ctrl_capture: assert property (rise_e && cnt_r == CTRL_LAST_CNT |=> ctrl_r == {$past(shift_r), $past(din_s)})
		else $error("control word not captured at eighth edge");
	a_repeat_frame: assert property (last_rise |=> cnt_r == 4'h0 && !hold && conv_done)
		else $error("new cycle not started after sixteen edges");
	a_lead_zero: assert property (fall_e && cnt_r < LEAD_ZERO_BITS |=> !dout)
		else $error("leading zero not shifted");
	a_idle_count: assert property (cs_n_s |=> cnt_r == 4'h0)
		else $error("counter not cleared while deselected");
endmodule

// ### verification/serial_host.sv
// behavioural host serial master: frames, clocks and reads the converter port
// assumes clock idles high, so the first edge after chip select falls is falling
`timescale 1ns/1ps
module serial_host
	import adc_seq_pkg::*;
(
	output logic sclk,
	output logic cs_n,
	output logic din,
	input wire logic dout
);
	// mode in force is the one written by the last complete frame
	logic [1:0] mode_sent = PM_RESET;
	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	initial
	begin
		sclk = 1'b1;
		cs_n = 1'b1;
		din = 1'b1;
	end

	// ----------------------------------------
	// transfers
	// ----------------------------------------
	// equal halves of 24 ns keep the duty at 50 percent, except the first low phase stretched after autoshutdown
	task automatic frame(input logic [7:0] w, input logic keep, output logic [15:0] rd);
		int i;
		if (cs_n)
		begin
			cs_n = 1'b0;
			#24;
		end
		for (i = 0; i < 16; i++)
		begin
			sclk = 1'b0;
			din = (i < 8) ? w[7-i] : 1'b0;
			#24;
			// wake time from full shutdown before the hold edge
			if (i == 0 && mode_sent == PM_AUTO_SHUTDOWN)
				#5000;
			sclk = 1'b1;
			rd = {rd[14:0], dout};
			#24;
		end
		if (!keep)
		begin
			cs_n = 1'b1;
			// released line must not keep showing the last bit
			din = ~din;
		end
		mode_sent = w[1:0];
	endtask

	task automatic idle_clocks(input int n);
		int i;
		for (i = 0; i < n; i++)
		begin
			sclk = 1'b0;
			#24;
			sclk = 1'b1;
			#24;
		end
	endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench for the converter serial/power sequencer
// assumes serial_host drives the pins; result_in held steady per frame
`timescale 1ns/1ps
module tb_top;
	import adc_seq_pkg::*;
	typedef struct packed {
		logic [1:0] m;
		logic [2:0] ch;
		logic [11:0] res;
		logic [1:0] pw;
	} row_s;
	row_s rows [0:3] = '{'{2'h0, 3'h3, 12'hA5C, 2'h3}, '{2'h3, 3'h5, 12'h123, 2'h1},
		'{2'h2, 3'h7, 12'hFFF, 2'h0}, '{2'h1, 3'h2, 12'h800, 2'h0}};
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [11:0] result_in = 12'h000;
	wire sclk;
	wire cs_n;
	wire din;
	logic dout, dout_oe, hold, conv_start, conv_done;
	logic [2:0] channel;
	power_s power;
	logic [1:0] power_mode;
	logic [15:0] rd;
	logic [2:0] prev_ch;
	int err_count = 0;
	int total_checks = 0;
	int starts = 0;
	int dones = 0;

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		if (conv_start === 1'b1) starts++;
		if (conv_done === 1'b1) dones++;
	end

	adc_serial_power_sequencer u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk(sclk),
		.cs_n(cs_n), .din(din), .result_in(result_in), .dout(dout), .dout_oe(dout_oe),
		.hold(hold), .conv_start(conv_start), .conv_done(conv_done), .channel(channel),
		.power(power), .power_mode(power_mode));
	// released data line reads as pulled high at the host
	serial_host u_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_oe ? dout : 1'b1));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
		total_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic run(input logic [1:0] m, input logic [2:0] ch, input logic keep);
		@(posedge ref_clk);
		#1;
		starts = 0;
		dones = 0;
		u_host.frame({3'h0, ch, m}, keep, rd);
		#60;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		#100000;
		err_count++;
		results();
	end

	initial
	begin
		repeat (8) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		repeat (4) @(posedge ref_clk);
		chk({power, power_mode}, 16'h000C, "reset power");
		chk(dout_oe, 16'h0000, "reset oe");
		prev_ch = 3'h0;
		foreach (rows[i])
		begin
			result_in = rows[i].res;
			run(rows[i].m, rows[i].ch, 1'b0);
			chk(rd, {4'h0, rows[i].res}, "read word");
			chk(channel, prev_ch, "channel");
			chk(power, rows[i].pw, "power");
			chk(power_mode, rows[i].m, "mode");
			chk(starts, 16'h0001, "starts");
			chk(dones, 16'h0001, "dones");
			chk({dout_oe, hold}, 16'h0000, "released");
			prev_ch = rows[i].ch;
		end
		// clocks outside a frame must not advance the bit count
		u_host.idle_clocks(5);
		result_in = 12'h3C6;
		run(PM_AUTO_SHUTDOWN, 3'h1, 1'b0);
		chk(rd, 16'h03C6, "gated read");
		chk(starts, 16'h0001, "gated starts");
		chk(power, 16'h0000, "still off");
		fork
			run(PM_AUTO_SHUTDOWN, 3'h6, 1'b1);
			begin
				#70;
				chk(power.core_on, 16'h0001, "wake");
				chk(hold, 16'h0000, "tracking");
				#5130;
				chk(hold, 16'h0001, "held");
			end
		join
		chk(power, 16'h0000, "auto off");
		result_in = 12'h5A1;
		run(PM_NORMAL, 3'h0, 1'b0);
		chk(starts, 16'h0001, "held cs start");
		chk(rd, 16'h05A1, "held cs read");
		chk(channel, 16'h0006, "held cs channel");
		chk(power, 16'h0003, "normal on");
		results();
	end
endmodule
